// *** rtl/mpg_regs.vh ***
// Constants for the pin glue block: register offsets, fields, reset values
`ifndef MPG_REGS_VH
`define MPG_REGS_VH
// Register byte offsets
`define MPG_OFS_PA_DDR    12'h000
`define MPG_OFS_PB_DDR    12'h004
`define MPG_OFS_PC_DDR    12'h008
`define MPG_OFS_PD_DDR    12'h00c
`define MPG_OFS_PIN_STAT  12'h010
`define MPG_OFS_CTRL      12'h014
// Control register fields
`define MPG_CTRL_STOP_BIT 0
`define MPG_CTRL_TIMER_COMPARE_OUT_BIT 1
`define MPG_CTRL_ACK_BIT  2
// Pin status register fields
`define MPG_ST_IRQ_BIT    0
`define MPG_ST_TIMER_CAPTURE_IN_BIT   1
`define MPG_ST_OSC_BIT    2
`define MPG_ST_INTRST_BIT 3
`define MPG_ST_PAIRQ_BIT  4
// Reset values and direction masks
`define MPG_DDR_RST       8'h00
`define MPG_PB_MASK       8'he0
`define MPG_PD_MASK       8'h20
// Reset pin stretch, in oscillator cycles
`define MPG_RST_STRETCH   8'h04
`endif

// *** rtl/mpg_top.v ***
// Chip-level pin glue: clock divide, reset pin, port reset directions, ext interrupt
// Behaviour
// - Bus clock is the oscillator clock divided by two.
// - With stop-to-halt conversion, software cannot stop the oscillator.
// - Low on the reset pin resets the whole chip.
// - Internal reset sources drive the reset pin low.
// - Port A eight lines programmable, inputs after any reset.
// - Per-pin option adds pullup and active-low interrupt on port A lines.
// - Port B three lines programmable, inputs after reset.
// - Port C eight lines programmable, inputs after reset.
// - Port D line 5 programmable, input after reset.
// - Port D line 7 always input, always readable.
// - Clock-out option makes line 5 a fixed buffered oscillator output; the code gives oscillator / 2.
// - Timer compare output is low after any reset.
// - Low on interrupt pin sets a request latch.
// - Latch tested at instruction end; start interrupt if mask bit clear.
// - Option selects falling edge only or edge plus low level.
// - Option sets serial shift clock to oscillator divided by 2 to 256.
// - Option selects serial MSB first or LSB first.
// - Options enable watchdog reset and low-voltage reset sources.
// - Option converts stop instruction into halt mode.
//
// Register access over APB and the register addresses were decided locally.
`include "mpg_regs.vh"
`default_nettype none
module mpg_top #(
    parameter       IRQ_EDGE_LEVEL = 1'b1,      // 1: edge and level, 0: edge only
    parameter       SER_MSB_FIRST  = 1'b1,      // Serial bit order
    parameter [2:0] SER_RATE_SEL   = 3'd0,      // Divide 2 << sel
    parameter       WDOG_EN        = 1'b1,      // Watchdog reset enable
    parameter       LVR_EN         = 1'b1,      // Low-voltage reset enable
    parameter       STOP_TO_HALT   = 1'b0,      // Stop converted to halt
    parameter       CLK_OUT_EN     = 1'b0,      // Line 5 carries clock out
    parameter [7:0] PA_IRQ_PULL    = 8'h00      // Per-line pullup/interrupt
) (
    input  wire        ref_clk,                 // Oscillator clock
    input  wire        rst_b,                   // Power-on reset, active low
    input  wire        psel,                    // APB select
    input  wire        penable,                 // APB enable
    input  wire        pwrite,                  // APB direction
    input  wire [11:0] paddr,                   // APB byte address
    input  wire [31:0] pwdata,                  // APB write data
    output reg         pready,                  // APB ready
    output reg  [31:0] prdata,                  // APB read data
    output reg         pslverr,                 // APB error
    input  wire        reset_pin_in,            // Reset pin level
    output reg         reset_pin_out,           // Reset pin drive value
    output reg         reset_pin_oe,            // Reset pin pull-down enable
    output reg         chip_rst_b,              // Chip reset, active low
    output reg         bus_clock_phase,         // Bus clock, osc / 2
    output reg         osc_run,                 // Oscillator enable
    input  wire        stop_req,                // CPU stop instruction
    output reg         halt_mode,               // Stop converted to halt
    input  wire        wdog_fire,               // Watchdog timeout
    input  wire        lvr_fire,                // Low-voltage detect
    output reg  [7:0]  port_a_oe,               // Port A direction
    output reg  [7:0]  port_a_pullup,           // Port A pullup enables
    input  wire [7:0]  port_a_lines,            // Port A pin levels
    output reg  [7:0]  port_b_oe,               // Port B direction
    output reg  [7:0]  port_c_oe,               // Port C direction
    output reg         port_d_line_5_oe,        // Line 5 drive enable
    output reg         clock_out_pin,           // Oscillator divided by two
    input  wire        timer_capture_in,        // Line 7 pin
    output reg         timer_capture_sync,      // Line 7 synchronised
    input  wire        timer_cmp_next,          // Timer compare level
    output reg         timer_compare_out,       // Compare pin
    input  wire        irq_pin_b,               // Interrupt pin, active low
    input  wire        insn_done,               // Instruction completes
    input  wire        cc_irq_mask,             // Mask bit of condition_code_reg
    output reg         irq_start,               // Begin interrupt sequence
    output reg  [2:0]  ser_rate_sel,            // Serial divide select
    output reg         ser_msb_first,           // Serial bit order
    output reg         wdog_en,                 // Watchdog enable
    output reg         lvr_en                   // Low-voltage reset enable
);

    // =========================================================
    // Synchronisers
    // Stages reset to each pin's idle level, so no false edge after reset
    // Port A levels feed status and the line interrupts
    reg  [1:0]  rst_pin_s;
    reg  [1:0]  irq_s;
    reg  [1:0]  timer_capture_in_s;
    reg  [1:0]  wd_s;
    reg  [1:0]  lv_s;
    reg  [7:0]  pa_s0;
    reg  [7:0]  pa_s1;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_pin_s <= 2'b11;
            irq_s     <= 2'b11;
            timer_capture_in_s    <= 2'b00;
            wd_s      <= 2'b00;
            lv_s      <= 2'b00;
            pa_s0     <= 8'hff;
            pa_s1     <= 8'hff;
        end else begin
            rst_pin_s <= {rst_pin_s[0], reset_pin_in};
            irq_s     <= {irq_s[0], irq_pin_b};
            timer_capture_in_s    <= {timer_capture_in_s[0], timer_capture_in};
            wd_s      <= {wd_s[0], wdog_fire};
            lv_s      <= {lv_s[0], lvr_fire};
            pa_s0     <= port_a_lines;
            pa_s1     <= pa_s0;
        end
    end

    // =========================================================
    // Reset pin, both directions
    // Internal sources reset the chip through the pin as well
    wire        int_rst = (WDOG_EN && wd_s[1]) || (LVR_EN && lv_s[1]);
    // Pin stays low a few cycles past the source so the board sees it
    reg  [7:0]  stretch_q;
    reg         int_rst_seen_q;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stretch_q      <= 8'h00;
            reset_pin_out  <= 1'b0;
            reset_pin_oe   <= 1'b0;
            chip_rst_b     <= 1'b0;
        end else begin
            if (int_rst)
                stretch_q <= `MPG_RST_STRETCH;
            else if (stretch_q != 8'h00)
                stretch_q <= stretch_q - 8'h01;
            reset_pin_out <= 1'b0;
            reset_pin_oe  <= int_rst || (stretch_q != 8'h00);
            chip_rst_b    <= rst_pin_s[1] && !int_rst;
        end
    end

    // Soft reset for registers, ports and interrupt logic
    wire        srst = !chip_rst_b;

    // =========================================================
    // Clock derivation and low-power
    // Clock out is osc/2: the raw oscillator cannot pass a flop
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_clock_phase <= 1'b0;
            clock_out_pin   <= 1'b0;
        end else begin
            bus_clock_phase <= ~bus_clock_phase;
            clock_out_pin   <= CLK_OUT_EN ? ~clock_out_pin : 1'b0;
        end
    end

    // Stop bit is ignored when stop is turned into halt
    reg         ctrl_stop_q;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            osc_run   <= 1'b1;
            halt_mode <= 1'b0;
        end else if (srst) begin
            osc_run   <= 1'b1;
            halt_mode <= 1'b0;
        end else begin
            osc_run   <= STOP_TO_HALT ? 1'b1 : !(stop_req || ctrl_stop_q);
            halt_mode <= STOP_TO_HALT && stop_req;
        end
    end

    // =========================================================
    // Fixed option outputs
    // Flops copy the options so every output comes from a register
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ser_rate_sel  <= 3'd0;
            ser_msb_first <= 1'b0;
            wdog_en       <= 1'b0;
            lvr_en        <= 1'b0;
            port_a_pullup <= 8'h00;
        end else begin
            ser_rate_sel  <= SER_RATE_SEL;
            ser_msb_first <= SER_MSB_FIRST;
            wdog_en       <= WDOG_EN;
            lvr_en        <= LVR_EN;
            port_a_pullup <= PA_IRQ_PULL;
        end
    end

    // =========================================================
    // APB registers
    // One wait state: a write commits on the first access edge,
    // ready and read data stand for the following cycle
    reg  [7:0]  pa_ddr_q;
    reg  [7:0]  pb_ddr_q;
    reg  [7:0]  pc_ddr_q;
    reg         pd_ddr_q;
    reg         timer_compare_out_ctl_q;
    reg         irq_latch_q;
    wire        acc   = psel && penable && !pready;
    wire        wr    = acc && pwrite;
    wire        ack_w = wr && (paddr == `MPG_OFS_CTRL) && pwdata[`MPG_CTRL_ACK_BIT];
    // Unmapped offsets answer with an error and read as zero
    reg         hit;

    always @* begin
        case (paddr)
            `MPG_OFS_PA_DDR,
            `MPG_OFS_PB_DDR,
            `MPG_OFS_PC_DDR,
            `MPG_OFS_PD_DDR,
            `MPG_OFS_PIN_STAT,
            `MPG_OFS_CTRL:     hit = 1'b1;
            default:           hit = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pa_ddr_q    <= `MPG_DDR_RST;
            pb_ddr_q    <= `MPG_DDR_RST;
            pc_ddr_q    <= `MPG_DDR_RST;
            pd_ddr_q    <= 1'b0;
            ctrl_stop_q <= 1'b0;
            timer_compare_out_ctl_q  <= 1'b0;
            pready      <= 1'b0;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
        end else if (srst) begin
            pa_ddr_q    <= `MPG_DDR_RST;
            pb_ddr_q    <= `MPG_DDR_RST;
            pc_ddr_q    <= `MPG_DDR_RST;
            pd_ddr_q    <= 1'b0;
            ctrl_stop_q <= 1'b0;
            timer_compare_out_ctl_q  <= 1'b0;
            pready      <= 1'b0;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
        end else begin
            pready  <= acc;
            pslverr <= acc && !hit;
            prdata  <= 32'h0000_0000;
            if (wr) begin
                case (paddr)
                    `MPG_OFS_PA_DDR: pa_ddr_q <= pwdata[7:0];
                    `MPG_OFS_PB_DDR: pb_ddr_q <= pwdata[7:0] & `MPG_PB_MASK;
                    `MPG_OFS_PC_DDR: pc_ddr_q <= pwdata[7:0];
                    `MPG_OFS_PD_DDR: pd_ddr_q <= pwdata[5];
                    `MPG_OFS_CTRL: begin
                        ctrl_stop_q <= pwdata[`MPG_CTRL_STOP_BIT] && !STOP_TO_HALT;
                        timer_compare_out_ctl_q  <= pwdata[`MPG_CTRL_TIMER_COMPARE_OUT_BIT];
                    end
                    default: ;
                endcase
            end else if (acc) begin
                case (paddr)
                    `MPG_OFS_PA_DDR:   prdata <= {24'h000000, pa_ddr_q};
                    `MPG_OFS_PB_DDR:   prdata <= {24'h000000, pb_ddr_q};
                    `MPG_OFS_PC_DDR:   prdata <= {24'h000000, pc_ddr_q};
                    `MPG_OFS_PD_DDR:   prdata <= {26'h0000000, pd_ddr_q, 5'h00};
                    `MPG_OFS_PIN_STAT: prdata <= {19'h00000, pa_s1, irq_latch_q,
                                                  int_rst_seen_q, osc_run,
                                                  timer_capture_in_s[1], !irq_s[1]};
                    `MPG_OFS_CTRL:     prdata <= {29'h00000000, 1'b0, timer_compare_out_ctl_q,
                                                  ctrl_stop_q};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Sticky internal-reset flag survives the soft reset it causes
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b)
            int_rst_seen_q <= 1'b0;
        else if (int_rst)
            int_rst_seen_q <= 1'b1;
        else if (ack_w)
            int_rst_seen_q <= 1'b0;
    end

    // =========================================================
    // Port directions and timer pins
    // Capture line passes on in chip reset too, so it reads at any time
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_a_oe          <= 8'h00;
            port_b_oe          <= 8'h00;
            port_c_oe          <= 8'h00;
            port_d_line_5_oe   <= 1'b0;
            timer_capture_sync <= 1'b0;
            timer_compare_out  <= 1'b0;
        end else if (srst) begin
            port_a_oe          <= 8'h00;
            port_b_oe          <= 8'h00;
            port_c_oe          <= 8'h00;
            port_d_line_5_oe   <= CLK_OUT_EN;
            timer_capture_sync <= timer_capture_in_s[1];
            timer_compare_out  <= 1'b0;
        end else begin
            port_a_oe          <= pa_ddr_q;
            port_b_oe          <= pb_ddr_q & `MPG_PB_MASK;
            port_c_oe          <= pc_ddr_q;
            port_d_line_5_oe   <= CLK_OUT_EN ? 1'b1 : pd_ddr_q;
            timer_capture_sync <= timer_capture_in_s[1];
            timer_compare_out  <= timer_cmp_next ^ timer_compare_out_ctl_q;
        end
    end

    // =========================================================
    // External interrupt latch and gating
    // Set wins over take, so a request in the take cycle is not lost
    reg         irq_prev_q;
    wire        irq_fall  = irq_prev_q && !irq_s[1];
    // Level mode keeps the latch set while the pin stays low
    wire        irq_level = IRQ_EDGE_LEVEL && !irq_s[1];
    wire [7:0]  pa_low;
    genvar      gi;

    // Fitted port A lines request while low
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pa_irq
            assign pa_low[gi] = PA_IRQ_PULL[gi] && !pa_s1[gi];
        end
    endgenerate
    wire        irq_set   = irq_fall || irq_level || (pa_low != 8'h00);
    wire        irq_take  = insn_done && irq_latch_q && !cc_irq_mask;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_prev_q  <= 1'b1;
            irq_latch_q <= 1'b0;
            irq_start   <= 1'b0;
        end else if (srst) begin
            irq_prev_q  <= 1'b1;
            irq_latch_q <= 1'b0;
            irq_start   <= 1'b0;
        end else begin
            irq_prev_q <= irq_s[1];
            irq_start  <= irq_take;
            if (irq_set)
                irq_latch_q <= 1'b1;
            else if (irq_take)
                irq_latch_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// *** verif/mpg_chk_sva.sv ***
// Checker for the pin glue block
`default_nettype none
module mpg_chk #(
    parameter       WDOG_EN      = 1'b1,
    parameter [2:0] SER_RATE_SEL = 3'd0,
    parameter       CLK_OUT_EN   = 1'b0,
    parameter [7:0] PA_IRQ_PULL  = 8'h00
) (
    input wire logic       ref_clk,            // Clock
    input wire logic       rst_b,              // Reset
    input wire logic       reset_pin_in,       // Pin level
    input wire logic       reset_pin_oe,       // Pin pull
    input wire logic       chip_rst_b,         // Chip reset
    input wire logic       bus_clock_phase,    // Bus clock
    input wire logic       wdog_fire,          // Watchdog
    input wire logic [7:0] port_a_oe,          // Dir A
    input wire logic [7:0] port_b_oe,          // Dir B
    input wire logic [7:0] port_c_oe,          // Dir C
    input wire logic       port_d_line_5_oe,   // Dir D5
    input wire logic [7:0] port_a_pullup,      // Pullups
    input wire logic       clock_out_pin,      // Clock out
    input wire logic       timer_capture_in,   // Capture pin
    input wire logic       timer_capture_sync, // Capture sync
    input wire logic       timer_compare_out,  // Compare pin
    input wire logic       irq_pin_b,          // Irq pin
    input wire logic       insn_done,          // Insn end
    input wire logic       cc_irq_mask,        // Mask bit
    input wire logic       irq_start,          // Irq begin
    input wire logic [2:0] ser_rate_sel,       // Rate
    input wire logic       wdog_en             // Wdog enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_held_rst;
        !chip_rst_b ##1 !chip_rst_b;
    endsequence
    sequence s_irq_wait;
        (chip_rst_b && !irq_pin_b && !insn_done)[*5];
    endsequence
    AST_BUS_CLK: assert property ($past(rst_b) |->
        bus_clock_phase != $past(bus_clock_phase))
        else $error("bus clock did not toggle");
    AST_CHIP_RST: assert property (!reset_pin_in[*4] |-> !chip_rst_b)
        else $error("reset pin low without chip reset");
    AST_RST_PIN: assert property ((WDOG_EN && wdog_fire)[*4] |-> reset_pin_oe)
        else $error("reset pin not pulled");
    AST_DIR_RST: assert property (s_held_rst |->
        {port_a_oe, port_b_oe, port_c_oe} == 24'h0 && port_d_line_5_oe == CLK_OUT_EN)
        else $error("port not input in reset");
    AST_CMP_LOW: assert property (s_held_rst |-> !timer_compare_out)
        else $error("compare out high in reset");
    AST_CAP: assert property ($past(rst_b, 3) |->
        timer_capture_sync == $past(timer_capture_in, 3))
        else $error("capture line lost");
    AST_IRQ_GO: assert property (s_irq_wait ##1
        (insn_done && !cc_irq_mask) |=> irq_start)
        else $error("interrupt not started");
    AST_IRQ_WHY: assert property (irq_start |-> $past(insn_done) && !$past(cc_irq_mask))
        else $error("interrupt started without cause");
    AST_OPT: assert property (chip_rst_b |->
        ser_rate_sel == SER_RATE_SEL && wdog_en == WDOG_EN
        && port_a_pullup == PA_IRQ_PULL && (CLK_OUT_EN || !clock_out_pin))
        else $error("option output wrong");
endmodule
bind mpg_top mpg_chk #(.WDOG_EN(WDOG_EN), .SER_RATE_SEL(SER_RATE_SEL),
    .CLK_OUT_EN(CLK_OUT_EN), .PA_IRQ_PULL(PA_IRQ_PULL)) u_chk (.*);
`default_nettype wire

// *** verif/mpg_board.sv ***
// Board and CPU model around the pin glue block
`default_nettype none
module mpg_board (
    input  wire logic ref_clk,       // Clock
    input  wire logic reset_pin_oe,  // Device pull
    input  wire logic reset_pin_out, // Device level
    input  wire logic ext_rst_b,     // Reset switch
    input  wire logic irq_drive_b,   // Irq source
    output var  logic reset_pin_in,  // Pin level
    output var  logic irq_pin_b,     // Irq pin
    output var  logic insn_done      // Insn end
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] step_q = 3'h0;
    // Pull-up, either party pulls low
    assign reset_pin_in = ext_rst_b & ~(reset_pin_oe & ~reset_pin_out);
    assign irq_pin_b = irq_drive_b;
    // Instruction ends every eighth cycle
    always @(posedge ref_clk) step_q <= step_q + 3'h1;
    assign insn_done = (step_q == 3'h7);
endmodule
`default_nettype wire

// *** verif/mcu_pin_glue_ext_interrupt_bench.sv ***
// Testbench for the pin glue block
`include "mpg_regs.vh"
`default_nettype none
`define CHK_EQ(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, a, b); end end
module mcu_pin_glue_ext_interrupt_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic        pready, pslverr, reset_pin_in, reset_pin_out, reset_pin_oe, chip_rst_b;
    logic        bus_clock_phase, osc_run, halt_mode, clock_out_pin, port_d_line_5_oe;
    logic        stop_req = 0, wdog_fire = 0, lvr_fire = 0, timer_capture_in = 0;
    logic        timer_cmp_next = 0, cc_irq_mask = 1, ext_rst_b = 1, irq_drive_b = 1;
    logic        timer_capture_sync, timer_compare_out, irq_pin_b, insn_done, irq_start;
    logic        ser_msb_first, wdog_en, lvr_en;
    logic [7:0]  port_a_oe, port_a_pullup, port_b_oe, port_c_oe, port_a_lines = 0;
    logic [7:0]  starts = 0;
    logic [2:0]  ser_rate_sel;
    int          bad_count = 0, compares = 0;
    mpg_top   i_dut (.*);
    mpg_board i_board (.*);
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (irq_start === 1'b1) starts <= starts + 8'h1;
    task automatic print_verdict;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following setup never re-drives psel in this step
        @(posedge ref_clk);
        if (n >= 20) begin
            bad_count++;
            print_verdict();
        end
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (chip_rst_b !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 40) begin
            bad_count++;
            print_verdict();
        end
    endtask
    task automatic t_ports;
        logic [31:0] q;
        logic        e;
        apb(1'b1, `MPG_OFS_PA_DDR, 32'hff, q, e);
        apb(1'b1, `MPG_OFS_PB_DDR, 32'hff, q, e);
        apb(1'b1, `MPG_OFS_PC_DDR, 32'h5a, q, e);
        apb(1'b1, `MPG_OFS_PD_DDR, 32'hff, q, e);
        apb(1'b0, `MPG_OFS_PB_DDR, 32'h0, q, e);
        `CHK_EQ(q, {24'h0, `MPG_PB_MASK})
        `CHK_EQ({port_a_oe, port_b_oe, port_c_oe, port_d_line_5_oe}, 25'h1ffc0b5)
        apb(1'b0, 12'h018, 32'h0, q, e);
        `CHK_EQ({e, q}, 33'h100000000)
    endtask
    task automatic t_inputs;
        logic [31:0] q;
        logic        e;
        port_a_lines <= 8'ha5;
        timer_capture_in <= 1'b1;
        repeat (4) @(posedge ref_clk);
        `CHK_EQ(timer_capture_sync, 1'b1)
        apb(1'b0, `MPG_OFS_PIN_STAT, 32'h0, q, e);
        `CHK_EQ({q[12:5], q[1]}, 9'h14b)
    endtask
    task automatic t_irq;
        logic [31:0] q;
        logic        e;
        irq_drive_b <= 1'b0;
        repeat (12) @(posedge ref_clk);
        apb(1'b0, `MPG_OFS_PIN_STAT, 32'h0, q, e);
        `CHK_EQ({starts, q[4], q[0]}, 10'h3)
        irq_drive_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        cc_irq_mask <= 1'b0;
        repeat (10) @(posedge ref_clk);
        `CHK_EQ(starts, 8'h1)
        irq_drive_b <= 1'b0;
        repeat (24) @(posedge ref_clk);
        `CHK_EQ(starts > 8'h2, 1'b1)
        irq_drive_b <= 1'b1;
        cc_irq_mask <= 1'b1;
    endtask
    task automatic t_reset;
        logic [31:0] q;
        logic        e;
        timer_cmp_next <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `MPG_OFS_PA_DDR, 32'hff, q, e);
            wdog_fire <= (i == 0);
            lvr_fire <= (i == 1);
            ext_rst_b <= (i != 2);
            repeat (6) @(posedge ref_clk);
            `CHK_EQ({chip_rst_b, port_a_oe, timer_compare_out}, 10'h0)
            `CHK_EQ(reset_pin_oe, i < 2)
            wdog_fire <= 1'b0;
            lvr_fire <= 1'b0;
            ext_rst_b <= 1'b1;
            wait_ready();
            apb(1'b0, `MPG_OFS_PIN_STAT, 32'h0, q, e);
            `CHK_EQ(q[3], i < 2)
            apb(1'b1, `MPG_OFS_CTRL, 32'h4, q, e);
        end
    endtask
    task automatic t_opts;
        logic [31:0] q;
        logic        e;
        `CHK_EQ({ser_msb_first, lvr_en, wdog_en, ser_rate_sel, reset_pin_out}, 7'h70)
        stop_req <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK_EQ({osc_run, halt_mode}, 2'b00)
        stop_req <= 1'b0;
        apb(1'b1, `MPG_OFS_CTRL, 32'h1, q, e);
        apb(1'b0, `MPG_OFS_PIN_STAT, 32'h0, q, e);
        `CHK_EQ({osc_run, q[2]}, 2'b00)
        apb(1'b1, `MPG_OFS_CTRL, 32'h0, q, e);
        `CHK_EQ(osc_run, 1'b1)
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        wait_ready();
        t_ports();
        t_inputs();
        t_opts();
        t_irq();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
